/* File: common/du_pkg.sv */
// constants, field layouts and types of the dual serial block
// Functional notes
// - registers take byte writes only; other lane patterns are refused
// - register block sits at 700h; channel A registers at listed offsets
// - one bits written to set or clear location set or clear output bits; the code ignores these writes while the halt bit is set, as it is after reset
// - command 20h resets receiver, 30h resets transmitter
// - command 45h clears error status, enables receiver and transmitter
// - baud set two with clock select BBh gives 9600 both ways
// - mode one 93h gives eight bits, no parity, receiver request control; the code disables that control whenever mode two txReqCtl is also set
// - status bit 3 reports transmitter empty
// - break start and break end each raise change-in-break interrupt
// - output pin function zero makes all pins plain outputs
// - channel mode 00 normal, 01 echo, 10 local loop, 11 remote loop
`default_nettype none
package du_pkg;
   localparam logic [11:0] SER_BASE = 12'h700;
   localparam logic [7:0] OFF_MODULE_CONFIG_HIGH = 8'h00;
   localparam logic [7:0] OFF_MODULE_CONFIG_LOW = 8'h01;
   localparam logic [7:0] OFF_IEN = 8'h04;
   localparam logic [7:0] OFF_ISTAT = 8'h05;
   localparam logic [7:0] OFF_MODE1 = 8'h10;
   localparam logic [7:0] OFF_STAT = 8'h11;
   localparam logic [7:0] OFF_CMD = 8'h12;
   localparam logic [7:0] OFF_DATA = 8'h13;
   localparam logic [7:0] OFF_AUX = 8'h14;
   localparam logic [7:0] OFF_OPF = 8'h1D;
   localparam logic [7:0] OFF_OPSET = 8'h1E;
   localparam logic [7:0] OFF_OPCLR = 8'h1F;
   localparam logic [7:0] OFF_MODE2 = 8'h20;
   localparam logic [7:0] MODULE_CONFIG_HIGH_RESET = 8'h80;
   localparam int HALT_BIT = 7;
   localparam int BAUD2_BIT = 7;
   localparam logic [3:0] CSR_9600 = 4'hB;
   localparam int BAUD_RATE = 9600;
   localparam int OVERSAMPLE = 16;
   localparam logic [2:0] MISC_RX_RESET = 3'h2;
   localparam logic [2:0] MISC_TX_RESET = 3'h3;
   localparam logic [2:0] MISC_ERR_RESET = 3'h4;
   localparam logic [2:0] MISC_BRK_RESET = 3'h5;
   localparam int ST_RXRDY = 0;
   localparam int ST_TXRDY = 2;
   localparam int ST_TXEMP = 3;
   localparam int IS_TXRDY = 0;
   localparam int IS_RXRDY = 1;
   localparam int IS_BRK = 2;
   localparam int IS_XTAL = 6;
   localparam int SETTLE_CYC = 1024;
   localparam logic [1:0] CM_NORMAL = 2'b00;
   localparam logic [1:0] CM_ECHO = 2'b01;
   localparam logic [1:0] CM_LOCAL = 2'b10;
   localparam logic [1:0] CM_REMOTE = 2'b11;
   localparam logic [1:0] PM_FORCE = 2'b01;
   localparam logic [1:0] PM_WITH = 2'b00;
   typedef struct packed {
      logic rxReqCtl;
      logic fullNotify;
      logic blockErr;
      logic [1:0] parityMode;
      logic parityType;
      logic [1:0] charLength;
   } du_mode_one_t;
   typedef struct packed {
      logic [1:0] channelMode;
      logic txReqCtl;
      logic txClearGate;
      logic [3:0] stopLength;
   } du_mode_two_t;
   typedef struct packed {
      logic [2:0] misc;
      logic txDisable;
      logic txEnable;
      logic rxDisable;
      logic rxEnable;
   } du_cmd_t;
   typedef enum logic [2:0] {DU_IDLE, DU_START, DU_DATA, DU_PAR, DU_STOP,
      DU_BRK} du_state_t;
endpackage : du_pkg
`default_nettype wire

/* File: verification/dual_uart_init_sequence_bench.sv */
// self-checking bench of the channel A serial block
`default_nettype none
module dual_uart_init_sequence_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CLKHZ = 614400;
   localparam int BITCYC = CLKHZ / du_pkg::BAUD_RATE;
   logic clk, reset, psel, penable, pwrite, pready, pslverr;
   logic rxd, ctsN, txd, irq, errFlag;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rdVal;
   logic [3:0] pstrb;
   logic [7:0] opPinN;
   int n_errors, compares;
   du_serial #(.CLK_HZ(CLKHZ), .SETTLE(16)) du_serial_inst (.clk(clk),
      .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rxd(rxd), .ctsN(ctsN),
      .txd(txd), .opPinN(opPinN), .irq(irq));
   // ****************************************************************
   // bus and compare tasks
   // ****************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] off,
      input logic [7:0] wd, input logic [3:0] st);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      pwdata <= {24'h000000, wd};
      pstrb <= st;
      paddr <= {2'b00, du_pkg::SER_BASE + {4'h0, off}, 2'b00};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
         n_errors++;
      rdVal = prdata;
      errFlag = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] off, input logic [7:0] d);
      apb(1'b1, off, d, 4'h1);
   endtask : wr
   task automatic rd(input logic [7:0] off);
      apb(1'b0, off, 8'h00, 4'h1);
   endtask : rd
   task automatic waitIrq(input logic lvl);
      int n;
      n = 0;
      while (irq !== lvl && n < 3000) begin
         @(posedge clk);
         n++;
      end
      @(negedge clk);
   endtask : waitIrq
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset;
      int n;
      n = 0;
      chk({24'h0, opPinN}, 32'h000000FF);
      chk({31'h0, txd}, 32'h1);
      chk({31'h0, irq}, 32'h0);
      rd(du_pkg::OFF_MODULE_CONFIG_HIGH);
      chk(rdVal, 32'h00000080);
      do begin
         rd(du_pkg::OFF_ISTAT);
         n++;
      end while (rdVal[du_pkg::IS_XTAL] !== 1'b0 && n < 40);
      chk({31'h0, rdVal[du_pkg::IS_XTAL]}, 32'h0);
      wr(du_pkg::OFF_MODULE_CONFIG_HIGH, 8'h00);
      $display("reset test done");
   endtask : t_reset
   task automatic t_port;
      wr(du_pkg::OFF_OPF, 8'h00);
      wr(du_pkg::OFF_OPSET, 8'h13);
      @(posedge clk);
      @(negedge clk);
      chk({24'h0, opPinN}, 32'h000000EC);
      wr(du_pkg::OFF_OPCLR, 8'h01);
      wr(du_pkg::OFF_OPSET, 8'h00);
      @(posedge clk);
      @(negedge clk);
      chk({24'h0, opPinN}, 32'h000000ED);
      apb(1'b0, 8'h30, 8'h00, 4'h1);
      chk({31'h0, errFlag}, 32'h1);
      $display("port test done");
   endtask : t_port
   task automatic t_mode;
      wr(du_pkg::OFF_CMD, 8'h20);
      wr(du_pkg::OFF_CMD, 8'h30);
      wr(du_pkg::OFF_AUX, 8'h80);
      wr(du_pkg::OFF_STAT, 8'hBB);
      wr(du_pkg::OFF_MODE1, 8'h93);
      rd(du_pkg::OFF_MODE1);
      chk(rdVal, 32'h00000093);
      for (int c = 3; c >= 0; c--) begin
         wr(du_pkg::OFF_MODE2, {2'(c), 6'h07});
         rd(du_pkg::OFF_MODE2);
         chk(rdVal, {24'h0, 2'(c), 6'h07});
      end
      apb(1'b1, du_pkg::OFF_MODE2, 8'h5A, 4'hF);
      chk({31'h0, errFlag}, 32'h1);
      rd(du_pkg::OFF_MODE2);
      chk(rdVal, 32'h00000007);
      wr(du_pkg::OFF_CMD, 8'h45);
      rd(du_pkg::OFF_STAT);
      chk({30'h0, rdVal[3:2]}, 32'h3);
      $display("mode test done");
   endtask : t_mode
   task automatic t_tx;
      int n;
      logic [8:0] frm;
      n = 0;
      frm = 9'h155;
      wr(du_pkg::OFF_DATA, 8'h55);
      rd(du_pkg::OFF_STAT);
      chk({31'h0, rdVal[du_pkg::ST_TXEMP]}, 32'h0);
      while (txd !== 1'b0 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      repeat (BITCYC / 2) @(negedge clk);
      chk({31'h0, txd}, 32'h0);
      for (int i = 0; i < 9; i++) begin
         repeat (BITCYC) @(negedge clk);
         chk({31'h0, txd}, {31'h0, frm[i]});
      end
      repeat (BITCYC) @(negedge clk);
      rd(du_pkg::OFF_STAT);
      chk({31'h0, rdVal[du_pkg::ST_TXEMP]}, 32'h1);
      $display("transmit test done");
   endtask : t_tx
   task automatic t_loop;
      int n;
      n = 0;
      wr(du_pkg::OFF_MODE2, {du_pkg::CM_LOCAL, 6'h07});
      wr(du_pkg::OFF_DATA, 8'hA5);
      do begin
         rd(du_pkg::OFF_STAT);
         n++;
      end while (rdVal[du_pkg::ST_RXRDY] !== 1'b1 && n < 400);
      chk({31'h0, txd}, 32'h1);
      chk({28'h0, rdVal[7:5], rdVal[0]}, 32'h1);
      rd(du_pkg::OFF_DATA);
      chk(rdVal, 32'h000000A5);
      wr(du_pkg::OFF_MODE2, 8'h07);
      $display("loopback test done");
   endtask : t_loop
   task automatic t_break;
      wr(du_pkg::OFF_IEN, 8'h04);
      rxd <= 1'b0;
      waitIrq(1'b1);
      chk({31'h0, irq}, 32'h1);
      rd(du_pkg::OFF_ISTAT);
      chk({31'h0, rdVal[du_pkg::IS_BRK]}, 32'h1);
      wr(du_pkg::OFF_ISTAT, 8'h04);
      wr(du_pkg::OFF_CMD, 8'h50);
      @(negedge clk);
      chk({31'h0, irq}, 32'h0);
      rxd <= 1'b1;
      waitIrq(1'b1);
      chk({31'h0, irq}, 32'h1);
      wr(du_pkg::OFF_IEN, 8'h00);
      @(negedge clk);
      chk({31'h0, irq}, 32'h0);
      wr(du_pkg::OFF_IEN, 8'h04);
      @(negedge clk);
      chk({31'h0, irq}, 32'h1);
      wr(du_pkg::OFF_ISTAT, 8'h04);
      wr(du_pkg::OFF_CMD, 8'h50);
      @(negedge clk);
      chk({31'h0, irq}, 32'h0);
      $display("break test done");
   endtask : t_break
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      repeat (30000) @(posedge clk);
      n_errors++;
      end_of_test();
   end
   initial begin
      n_errors = 0;
      compares = 0;
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 16'h0000;
      pwdata = 32'h00000000;
      pstrb = 4'h0;
      rxd = 1'b1;
      ctsN = 1'b0;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      @(negedge clk);
      t_reset();
      t_port();
      t_mode();
      t_tx();
      t_loop();
      t_break();
      end_of_test();
   end
endmodule : dual_uart_init_sequence_bench
`default_nettype wire

/* File: verilog/du_serial.sv */
// channel A serial block with APB register access
//
// Local design decision: the APB register port.
`default_nettype none
module du_serial #(
   parameter int CLK_HZ = 125000000,
   parameter int SETTLE = du_pkg::SETTLE_CYC
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [15:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rxd,
   input wire logic ctsN,
   output logic txd,
   output logic [7:0] opPinN,
   output logic irq
);
   localparam int DIV = CLK_HZ / (du_pkg::OVERSAMPLE * du_pkg::BAUD_RATE);
   // ***************************************************************
   // register access
   // ***************************************************************
   logic [7:0] module_config_high, module_config_low, intEn, intStat, aux, clock_select, opFunc, opData;
   du_pkg::du_mode_one_t mode1;
   du_pkg::du_mode_two_t mode2;
   logic [7:0] wbyte, off, rxHold, txHold, rdByte;
   logic hit, access, wr, rd, badStrb, halted;
   logic rxEn, txEn, rxRdy, txFull, overrun, parErr, frmErr, brkRx;
   logic txEmpty, txRdy, settling;
   logic [1:0] rxS, ctsS;
   du_pkg::du_cmd_t cmd;

   function automatic logic [7:0] offOf(input logic [15:0] a);
      offOf = a[9:2];
   endfunction : offOf

   assign hit = paddr[15:14] == 2'h0
      && paddr[13:10] == du_pkg::SER_BASE[11:8] && paddr[1:0] == 2'h0
      && (offOf(paddr) <= du_pkg::OFF_MODE2);
   assign off = offOf(paddr);
   assign access = psel && penable;
   assign badStrb = pwrite && pstrb != 4'h1;
   assign wr = access && pwrite && hit && !badStrb;
   assign rd = access && !pwrite && hit;
   assign wbyte = pwdata[7:0];
   assign cmd = du_pkg::du_cmd_t'(wbyte[6:0]);
   assign pready = 1'b1;
   assign pslverr = access && (!hit || badStrb);
   assign halted = module_config_high[du_pkg::HALT_BIT];

   always_comb begin
      case (off)
         du_pkg::OFF_MODULE_CONFIG_HIGH: rdByte = module_config_high;
         du_pkg::OFF_MODULE_CONFIG_LOW: rdByte = module_config_low;
         du_pkg::OFF_IEN: rdByte = intEn;
         du_pkg::OFF_ISTAT: rdByte = intStat;
         du_pkg::OFF_MODE1: rdByte = mode1;
         du_pkg::OFF_STAT: rdByte = {brkRx, frmErr, parErr, overrun, txEmpty,
            txRdy, rxRdy, rxRdy};
         du_pkg::OFF_DATA: rdByte = rxHold;
         du_pkg::OFF_OPF: rdByte = opFunc;
         du_pkg::OFF_MODE2: rdByte = mode2;
         default: rdByte = 8'h00;
      endcase
   end

   // read data is captured in the setup phase, so reads take no wait
   always_ff @(posedge clk) begin
      if (reset)
         prdata <= 32'h0;
      else if (psel && !penable && !pwrite)
         prdata <= hit ? {24'h0, rdByte} : 32'h0;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         module_config_high <= du_pkg::MODULE_CONFIG_HIGH_RESET;
         module_config_low <= 8'h00;
         intEn <= 8'h00;
         aux <= 8'h00;
         clock_select <= 8'h00;
         opFunc <= 8'h00;
         mode1 <= '0;
         mode2 <= '0;
      end else if (wr) begin
         case (off)
            du_pkg::OFF_MODULE_CONFIG_HIGH: module_config_high <= wbyte;
            du_pkg::OFF_MODULE_CONFIG_LOW: module_config_low <= wbyte;
            du_pkg::OFF_IEN: intEn <= wbyte;
            du_pkg::OFF_AUX: aux <= wbyte;
            du_pkg::OFF_STAT: clock_select <= wbyte;
            du_pkg::OFF_OPF: opFunc <= wbyte;
            du_pkg::OFF_MODE1: if (!halted) mode1 <= wbyte;
            du_pkg::OFF_MODE2: if (!halted) mode2 <= wbyte;
            default: ;
         endcase
      end
   end

   // ***************************************************************
   // baud tick and crystal settling
   // ***************************************************************
   localparam int SETW = $clog2(SETTLE + 1);
   logic [15:0] divCnt;
   logic [SETW-1:0] settleCnt;
   logic tick, rxTickOk, txTickOk;
   assign tick = divCnt == 16'(DIV - 1);
   assign rxTickOk = aux[du_pkg::BAUD2_BIT] && clock_select[7:4] == du_pkg::CSR_9600;
   assign txTickOk = aux[du_pkg::BAUD2_BIT] && clock_select[3:0] == du_pkg::CSR_9600;
   assign settling = settleCnt != '0;

   always_ff @(posedge clk) begin
      if (reset || tick)
         divCnt <= 16'h0;
      else
         divCnt <= divCnt + 16'h1;
   end

   always_ff @(posedge clk) begin
      if (reset)
         settleCnt <= SETW'(SETTLE);
      else if (settling)
         settleCnt <= settleCnt - SETW'(1);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rxS <= 2'b11;
         ctsS <= 2'b11;
      end else begin
         rxS <= {rxS[0], rxd};
         ctsS <= {ctsS[0], ctsN};
      end
   end

   // ***************************************************************
   // channel mode routing
   // ***************************************************************
   logic txLine, rxLine, rxTick, txTick;
   logic [3:0] bitsLen;
   assign bitsLen = 4'd5 + {2'b00, mode1.charLength};
   assign rxLine = mode2.channelMode == du_pkg::CM_LOCAL ? txLine : rxS[1];
   assign rxTick = tick && rxTickOk;
   assign txTick = tick && txTickOk;

   always_ff @(posedge clk) begin
      if (reset)
         txd <= 1'b1;
      else case (mode2.channelMode)
         du_pkg::CM_NORMAL: txd <= txLine;
         du_pkg::CM_LOCAL: txd <= 1'b1;
         default: txd <= rxS[1];
      endcase
   end

   // ***************************************************************
   // receiver
   // ***************************************************************
   du_pkg::du_state_t rxSt;
   logic [3:0] rxCnt, rxBit;
   logic [7:0] rxSh, rxData;
   logic rxPar, rxLoad, brkEdge, rxDrain, expPar;
   assign rxData = rxSh >> (4'd8 - bitsLen);
   assign expPar = mode1.parityMode == du_pkg::PM_FORCE ? mode1.parityType
      : ^rxData ^ mode1.parityType;
   assign rxDrain = rd && off == du_pkg::OFF_DATA;

   always_ff @(posedge clk) begin
      rxLoad <= 1'b0;
      brkEdge <= 1'b0;
      if (reset || !rxEn || mode2.channelMode == du_pkg::CM_REMOTE) begin
         rxSt <= du_pkg::DU_IDLE;
         rxCnt <= 4'h0;
         rxBit <= 4'h0;
         rxSh <= 8'h0;
         rxPar <= 1'b0;
      end else if (rxSt == du_pkg::DU_BRK) begin
         if (rxLine) begin
            rxSt <= du_pkg::DU_IDLE;
            brkEdge <= 1'b1;
         end
      end else if (rxSt == du_pkg::DU_IDLE) begin
         rxCnt <= 4'h0;
         if (!rxLine)
            rxSt <= du_pkg::DU_START;
      end else if (rxTick) begin
         rxCnt <= rxCnt + 4'h1;
         case (rxSt)
            du_pkg::DU_START: if (rxCnt == 4'h7) begin
               rxCnt <= 4'h0;
               rxBit <= 4'h0;
               rxSt <= rxLine ? du_pkg::DU_IDLE : du_pkg::DU_DATA;
            end
            du_pkg::DU_DATA: if (rxCnt == 4'hF) begin
               rxSh <= {rxLine, rxSh[7:1]};
               rxBit <= rxBit + 4'h1;
               if (rxBit == bitsLen - 4'h1)
                  rxSt <= mode1.parityMode[1] ? du_pkg::DU_STOP
                     : du_pkg::DU_PAR;
            end
            du_pkg::DU_PAR: if (rxCnt == 4'hF) begin
               rxPar <= rxLine;
               rxSt <= du_pkg::DU_STOP;
            end
            du_pkg::DU_STOP: if (rxCnt == 4'hF) begin
               if (!rxLine && rxData == 8'h0 && !rxPar) begin
                  rxSt <= du_pkg::DU_BRK;
                  brkEdge <= 1'b1;
               end else begin
                  rxSt <= du_pkg::DU_IDLE;
                  rxLoad <= 1'b1;
               end
               rxPar <= 1'b0;
            end
            default: rxSt <= du_pkg::DU_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rxHold <= 8'h0;
         rxRdy <= 1'b0;
         overrun <= 1'b0;
         parErr <= 1'b0;
         frmErr <= 1'b0;
         brkRx <= 1'b0;
      end else begin
         if (rxLoad) begin
            rxHold <= rxData;
            rxRdy <= 1'b1;
            overrun <= overrun || rxRdy;
            parErr <= !mode1.parityMode[1] && rxPar != expPar;
            frmErr <= !rxLine;
         end else if (rxDrain)
            rxRdy <= 1'b0;
         if (brkEdge)
            brkRx <= rxSt == du_pkg::DU_BRK;
         if (wr && off == du_pkg::OFF_CMD) begin
            if (cmd.misc == du_pkg::MISC_RX_RESET) begin
               rxRdy <= 1'b0;
               overrun <= 1'b0;
            end
            if (cmd.misc == du_pkg::MISC_ERR_RESET) begin
               overrun <= 1'b0;
               parErr <= 1'b0;
               frmErr <= 1'b0;
               brkRx <= 1'b0;
            end
         end
      end
   end

   // ***************************************************************
   // transmitter
   // ***************************************************************
   du_pkg::du_state_t txSt;
   logic [4:0] txCnt;
   logic [3:0] txBit;
   logic [7:0] txSh;
   logic txGo;
   assign txRdy = txEn && !txFull;
   assign txEmpty = txEn && !txFull && txSt == du_pkg::DU_IDLE;
   assign txGo = txFull && (!mode2.txClearGate || !ctsS[1]);

   always_ff @(posedge clk) begin
      if (reset || !txEn) begin
         txSt <= du_pkg::DU_IDLE;
         txLine <= 1'b1;
         txCnt <= 5'h0;
         txBit <= 4'h0;
         txSh <= 8'h0;
      end else if (txTick) begin
         txCnt <= txCnt + 5'h1;
         case (txSt)
            du_pkg::DU_IDLE: begin
               txCnt <= 5'h0;
               if (txGo) begin
                  txSh <= txHold;
                  txLine <= 1'b0;
                  txSt <= du_pkg::DU_START;
               end
            end
            du_pkg::DU_START, du_pkg::DU_DATA: if (txCnt == 5'hF) begin
               txCnt <= 5'h0;
               txLine <= txSh[0];
               txSh <= txSh >> 1;
               txBit <= txSt == du_pkg::DU_START ? 4'h1 : txBit + 4'h1;
               txSt <= du_pkg::DU_DATA;
               if (txSt == du_pkg::DU_DATA && txBit == bitsLen) begin
                  txSt <= mode1.parityMode[1] ? du_pkg::DU_STOP
                     : du_pkg::DU_PAR;
                  txLine <= mode1.parityMode[1] ? 1'b1
                     : mode1.parityMode == du_pkg::PM_FORCE
                     ? mode1.parityType : ^txHold ^ mode1.parityType;
               end
            end
            du_pkg::DU_PAR: if (txCnt == 5'hF) begin
               txCnt <= 5'h0;
               txLine <= 1'b1;
               txSt <= du_pkg::DU_STOP;
            end
            du_pkg::DU_STOP:
               if (txCnt == (mode2.stopLength[3] ? 5'h1F : 5'hF))
                  txSt <= du_pkg::DU_IDLE;
            default: txSt <= du_pkg::DU_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         txFull <= 1'b0;
         txHold <= 8'h0;
      end else if (wr && off == du_pkg::OFF_DATA && txEn) begin
         txFull <= 1'b1;
         txHold <= wbyte & (8'hFF >> (4'd8 - bitsLen));
      end else if (txTick && txSt == du_pkg::DU_IDLE && txGo)
         txFull <= 1'b0;
      else if (wr && off == du_pkg::OFF_CMD
            && cmd.misc == du_pkg::MISC_TX_RESET)
         txFull <= 1'b0;
   end

   // ***************************************************************
   // command enables
   // ***************************************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         rxEn <= 1'b0;
         txEn <= 1'b0;
      end else if (wr && off == du_pkg::OFF_CMD) begin
         if (cmd.misc == du_pkg::MISC_RX_RESET)
            rxEn <= 1'b0;
         else if (cmd.rxDisable)
            rxEn <= 1'b0;
         else if (cmd.rxEnable)
            rxEn <= 1'b1;
         if (cmd.misc == du_pkg::MISC_TX_RESET)
            txEn <= 1'b0;
         else if (cmd.txDisable)
            txEn <= 1'b0;
         else if (cmd.txEnable)
            txEn <= 1'b1;
      end
   end

   // ***************************************************************
   // output port and request-to-send
   // ***************************************************************
   logic autoRts, txDone, rtsCtl;
   logic [7:0] pinVal;
   assign rtsCtl = mode1.rxReqCtl ^ mode2.txReqCtl;
   assign autoRts = rtsCtl && ((mode1.rxReqCtl && rxRdy)
      || (mode2.txReqCtl && txDone));

   always_ff @(posedge clk) begin
      if (reset)
         txDone <= 1'b0;
      else
         txDone <= txEn && txSt == du_pkg::DU_STOP && txTick
            && !txFull && txCnt == (mode2.stopLength[3] ? 5'h1F : 5'hF);
   end

   always_ff @(posedge clk) begin
      if (reset)
         opData <= 8'h00;
      else begin
         if (wr && !halted && off == du_pkg::OFF_OPSET)
            opData <= opData | wbyte;
         else if (wr && !halted && off == du_pkg::OFF_OPCLR)
            opData <= opData & ~wbyte;
         if (autoRts)
            opData[0] <= 1'b0;
      end
   end

   always_comb begin
      pinVal = opData;
      if (opFunc[6])
         pinVal[6] = txRdy;
      if (opFunc[4])
         pinVal[4] = rxRdy;
   end

   always_ff @(posedge clk) begin
      if (reset)
         opPinN <= 8'hFF;
      else
         opPinN <= ~pinVal;
   end

   // ***************************************************************
   // interrupts
   // ***************************************************************
   logic [7:0] evt, clr;
   logic txRdyQ;
   always_ff @(posedge clk) begin
      if (reset)
         txRdyQ <= 1'b0;
      else
         txRdyQ <= txRdy;
   end
   always_comb begin
      evt = 8'h00;
      evt[du_pkg::IS_TXRDY] = txRdy && !txRdyQ;
      evt[du_pkg::IS_RXRDY] = rxLoad;
      evt[du_pkg::IS_BRK] = brkEdge;
      clr = (wr && off == du_pkg::OFF_ISTAT) ? wbyte : 8'h00;
      if (wr && off == du_pkg::OFF_CMD && cmd.misc == du_pkg::MISC_BRK_RESET)
         clr[du_pkg::IS_BRK] = 1'b1;
   end
   always_ff @(posedge clk) begin
      if (reset)
         intStat <= 8'h00;
      else begin
         intStat <= (intStat & ~clr) | evt;
         intStat[du_pkg::IS_XTAL] <= settling;
      end
   end
   assign irq = |(intStat & intEn & ~(8'h1 << du_pkg::IS_XTAL));

   // ***************************************************************
   // checks
   // ***************************************************************
   sequence s_cmd(logic [7:0] v);
      wr && off == du_pkg::OFF_CMD && wbyte == v;
   endsequence
   property p_byte_only;
      @(posedge clk) disable iff (reset)
         access && pwrite && pstrb != 4'h1 |-> pslverr;
   endproperty
   a_byte_only: assert property (p_byte_only) else $error("wide write taken");
   property p_bit_set;
      @(posedge clk) disable iff (reset) wr && !halted && !autoRts
         && off == du_pkg::OFF_OPSET |=> (opData & $past(wbyte))
         == $past(wbyte);
   endproperty
   a_bit_set: assert property (p_bit_set) else $error("bit set lost");
   property p_bit_clr;
      @(posedge clk) disable iff (reset) wr && !halted && !autoRts
         && off == du_pkg::OFF_OPCLR |=> (opData & $past(wbyte)) == 8'h00
         && (opData | $past(wbyte)) == ($past(opData) | $past(wbyte));
   endproperty
   a_bit_clr: assert property (p_bit_clr) else $error("bit clear wrong");
   property p_rx_reset;
      @(posedge clk) disable iff (reset)
         s_cmd(8'h20) |=> !rxEn && !rxRdy ##1 rxSt == du_pkg::DU_IDLE;
   endproperty
   a_rx_reset: assert property (p_rx_reset) else $error("rx not reset");
   property p_tx_reset;
      @(posedge clk) disable iff (reset)
         s_cmd(8'h30) |=> !txEn && !txFull ##1 txLine;
   endproperty
   a_tx_reset: assert property (p_tx_reset) else $error("tx not reset");
   property p_enable;
      @(posedge clk) disable iff (reset) s_cmd(8'h45) |=> rxEn && txEn
         && !overrun && !parErr && !frmErr;
   endproperty
   a_enable: assert property (p_enable) else $error("enable failed");
   property p_tx_empty;
      @(posedge clk) disable iff (reset) psel && !penable && !pwrite && hit
         && off == du_pkg::OFF_STAT |=> prdata[du_pkg::ST_TXEMP]
         == $past(txEmpty);
   endproperty
   a_tx_empty: assert property (p_tx_empty) else $error("empty bit wrong");
   property p_break_irq;
      @(posedge clk) disable iff (reset)
         brkEdge |=> intStat[du_pkg::IS_BRK] [*2];
   endproperty
   a_break_irq: assert property (p_break_irq) else $error("break lost");
   property p_plain_pins;
      @(posedge clk) disable iff (reset)
         opFunc == 8'h00 |=> opPinN == ~$past(opData);
   endproperty
   a_plain_pins: assert property (p_plain_pins) else $error("pin wrong");
   property p_local_loop;
      @(posedge clk) disable iff (reset)
         mode2.channelMode == du_pkg::CM_LOCAL |=> txd;
   endproperty
   a_local_loop: assert property (p_local_loop) else $error("line driven");
endmodule : du_serial
`default_nettype wire
